// file: src/adc_params.svh
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH
// ***************************************************************
// Register map
// ***************************************************************
`define ADC_OFS_CTRL0     8'h00
`define ADC_OFS_CTRL1     8'h01
`define ADC_OFS_RESULT    8'h02
`define ADC_OFS_IRQ       8'h03
`define ADC_CTRL0_RESET   8'h00
`define ADC_CTRL1_RESET   3'h0
`define ADC_RESULT_RESET  8'h00
// ***************************************************************
// Field positions
// ***************************************************************
`define ADC_EN_BIT        0
`define ADC_GO_BIT        2
`define ADC_CHS_LSB       3
`define ADC_CHS_MSB       5
`define ADC_CKS_LSB       6
`define ADC_CKS_MSB       7
`define ADC_PCFG_MSB      2
`define ADC_DONE_BIT      0
`define ADC_IRQEN_BIT     1
// ***************************************************************
// Clock select codes and timing
// ***************************************************************
`define ADC_CKS_DIV2      2'h0
`define ADC_CKS_DIV8      2'h1
`define ADC_CKS_DIV32     2'h2
`define ADC_CKS_RC        2'h3
`define ADC_HALF_DIV2     5'h01
`define ADC_HALF_DIV8     5'h04
`define ADC_HALF_DIV32    5'h10
`define ADC_INSTR_CLKS    3'h4
`define ADC_SETUP_HALVES  5'h03
`define ADC_TOTAL_HALVES  5'h13
`define ADC_RECOV_HALVES  3'h4
`define ADC_MSB_INDEX     3'h7
`define ADC_SAR_SEED      8'h80
`endif

// file: src/adc_pkg.sv
package adc_pkg;
  // ***************************************************************
  // Types shared by the converter files
  // ***************************************************************
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_RC_WAIT = 4'b0010,
    ST_CONV    = 4'b0100,
    ST_RECOVER = 4'b1000
  } conv_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic       powered;
    logic       sample_hold;
    logic       ext_vref;
    logic [1:0] channel;
    logic [3:0] analog_mask;
    logic [7:0] trial;
  } analog_ctl_t;
endpackage : adc_pkg

// file: src/rc_edge_sync.sv
`timescale 1ns/1ns
`include "adc_params.svh"
module rc_edge_sync
  import adc_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Free running RC oscillator
  input  wire logic rc_clk_in,
  // One pulse per RC edge
  output logic      rc_edge
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic edge_ff;

  // ***************************************************************
  // Two-flop synchroniser, edge taken from the settled stages
  // ***************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff   <= 1'b0;
      s2_ff   <= 1'b0;
      s3_ff   <= 1'b0;
      edge_ff <= 1'b0;
    end else begin
      s1_ff   <= rc_clk_in;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      edge_ff <= s2_ff ^ s3_ff;
    end
  end

  assign rc_edge = edge_ff;

  // Every settled change yields exactly one pulse
  edge_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    (s2_ff != s3_ff) |=> rc_edge) else $error("rc edge pulse missing");
endmodule : rc_edge_sync

// file: src/tad_tick_gen.sv
`timescale 1ns/1ns
`include "adc_params.svh"
module tad_tick_gen
  import adc_pkg::*;
#(
  parameter int DIV_W = 5
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] clk_sel,
  input  wire logic       rc_edge,
  // Half bit-period tick
  output logic            half_tick
);
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] limit;
  logic             tick_ff;

  if (DIV_W < 5) begin : g_bad_width
    $error("tad_tick_gen: DIV_W too small for the slowest divider");
  end

  // Half period length in system clocks for each select code
  always_comb begin
    case (clk_sel)
      `ADC_CKS_DIV2:  limit = DIV_W'(`ADC_HALF_DIV2);
      `ADC_CKS_DIV8:  limit = DIV_W'(`ADC_HALF_DIV8);
      default:        limit = DIV_W'(`ADC_HALF_DIV32);
    endcase
  end

  // ***************************************************************
  // Divider; restarts whenever the sequencer is idle
  // ***************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (!run) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (clk_sel == `ADC_CKS_RC) begin
      div_ff  <= '0;
      tick_ff <= rc_edge;
    end else if (div_ff == limit - DIV_W'(1)) begin
      div_ff  <= '0;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + DIV_W'(1);
      tick_ff <= 1'b0;
    end
  end

  assign half_tick = tick_ff;

  // Fastest setting ticks on every clock while running
  fast_tick_a: assert property (@(posedge clock) disable iff (!rst_n)
    run && $past(run) && clk_sel == `ADC_CKS_DIV2 && $stable(clk_sel) |=> half_tick)
    else $error("divide-by-two tick missing");
endmodule : tad_tick_gen

// file: src/adc_conversion_control.sv
// How it works
// - Clearing go mid-conversion abandons it; result keeps previous value.
// - After abort wait two bit periods, then acquisition restarts automatically.
// - Reset clears all registers, powers converter off, cancels conversion.
// - RC clock selected: start waits one extra instruction cycle.
// - RC conversion finishing in sleep with interrupt enabled wakes device.
// - Finishing in sleep with interrupt off powers down; enable reads set.
// - Sleep on non-RC clock aborts and powers down; enable reads set.
// - Special event trigger sets go and clears the timer counter.
// - Clock select 00/01/10/11 gives /2, /8, /32, RC clock.
// - Channel codes 0..3 pick inputs; codes 4..7 reserved.
// - Go at bit 2: write one starts, reads one while busy.
// - Enable at bit 0; zero removes converter power.
// - Unimplemented control bits read as zero.
// - Pin configuration code selects analog pins and reference source.
// - Completion clears go, sets done flag, loads new result.
// - A conversion takes nine and a half bit periods.
// - Done flag set after every completed conversion; cleared only by software or reset.
// - Eight-bit result built by successive approximation.
`timescale 1ns/1ns
`include "adc_params.svh"
module adc_conversion_control
  import adc_pkg::*;
#(
  parameter int DIV_W = 5
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Register port
  input  wire reg_req_t    req,
  output logic [7:0]       rdata,
  // System events
  input  wire logic        sleep_active,
  input  wire logic        special_trigger,
  output logic             timer1_clear,
  output logic             wake_request,
  // Analog side
  input  wire logic        rc_clk_in,
  input  wire logic        comp_in,
  output analog_ctl_t      analog
);
  // ***************************************************************
  // Software registers and sequencer state
  // ***************************************************************
  logic [1:0]  conv_clock_select_ff;
  logic [2:0]  channel_select_ff;
  logic        conv_enable_bit_ff;
  logic [2:0]  pin_config_select_ff;
  logic [7:0]  conv_result_ff;
  logic        conv_done_flag_ff;
  logic        conv_done_irq_enable_ff;
  logic        sleep_off_ff;
  conv_state_t state_ff;
  conv_state_t nxt_state;
  logic [4:0]  half_cnt_ff;
  logic [2:0]  wait_cnt_ff;
  logic [2:0]  bit_ix_ff;
  logic [7:0]  sar_ff;
  logic [7:0]  rdata_ff;
  logic        timer1_clear_ff;
  logic        wake_ff;
  analog_ctl_t analog_ff;
  logic        half_tick;
  logic        rc_edge;
  logic        wr_ctrl0;
  logic        go_written;
  logic        go_cleared;
  logic        start_req;
  logic        finish;
  logic        sleep_abort;
  logic        on_rc;
  logic [7:0]  decided;

  assign wr_ctrl0    = req.wr && req.addr == `ADC_OFS_CTRL0;
  assign go_written  = wr_ctrl0 && req.wdata[`ADC_GO_BIT];
  assign go_cleared  = wr_ctrl0 && !req.wdata[`ADC_GO_BIT];
  assign on_rc       = conv_clock_select_ff == `ADC_CKS_RC;
  // Disabled converter ignores both start sources
  assign start_req   = (go_written || special_trigger) && conv_enable_bit_ff
                       && (!wr_ctrl0 || req.wdata[`ADC_EN_BIT]) && !sleep_off_ff;
  assign finish      = state_ff == ST_CONV && half_tick && !go_cleared && !sleep_abort
                       && half_cnt_ff == `ADC_TOTAL_HALVES - 5'h01;
  assign sleep_abort = sleep_active && !on_rc
                       && (state_ff == ST_CONV || state_ff == ST_RC_WAIT);

  // Current trial bit replaced by the comparator decision
  always_comb begin
    decided = sar_ff;
    decided[bit_ix_ff] = comp_in;
  end

  rc_edge_sync u_rc_sync (
    .clock     (clock),
    .rst_n     (rst_n),
    .rc_clk_in (rc_clk_in),
    .rc_edge   (rc_edge)
  );

  tad_tick_gen #(.DIV_W(DIV_W)) u_tick (
    .clock     (clock),
    .rst_n     (rst_n),
    .run       (state_ff == ST_CONV || state_ff == ST_RECOVER),
    .clk_sel   (conv_clock_select_ff),
    .rc_edge   (rc_edge),
    .half_tick (half_tick)
  );

  // ***************************************************************
  // Control registers
  // ***************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conv_clock_select_ff    <= 2'(`ADC_CTRL0_RESET >> `ADC_CKS_LSB);
      channel_select_ff       <= 3'(`ADC_CTRL0_RESET >> `ADC_CHS_LSB);
      conv_enable_bit_ff      <= 1'(`ADC_CTRL0_RESET >> `ADC_EN_BIT);
      pin_config_select_ff    <= `ADC_CTRL1_RESET;
      conv_done_irq_enable_ff <= 1'b0;
    end else if (req.wr) begin
      case (req.addr)
        `ADC_OFS_CTRL0: begin
          conv_clock_select_ff <= req.wdata[`ADC_CKS_MSB:`ADC_CKS_LSB];
          channel_select_ff    <= req.wdata[`ADC_CHS_MSB:`ADC_CHS_LSB];
          conv_enable_bit_ff   <= req.wdata[`ADC_EN_BIT];
        end
        `ADC_OFS_CTRL1: pin_config_select_ff <= req.wdata[`ADC_PCFG_MSB:0];
        `ADC_OFS_IRQ:   conv_done_irq_enable_ff <= req.wdata[`ADC_IRQEN_BIT];
        default: ;
      endcase
    end
  end

  // Done flag: hardware set wins over a same-cycle software clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conv_done_flag_ff <= 1'b0;
    end else if (finish) begin
      conv_done_flag_ff <= 1'b1;
    end else if (req.wr && req.addr == `ADC_OFS_IRQ) begin
      conv_done_flag_ff <= req.wdata[`ADC_DONE_BIT];
    end
  end

  // Sleep power-down; enable bit stays set, cleared on wake
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sleep_off_ff <= 1'b0;
    end else if (!sleep_active) begin
      sleep_off_ff <= 1'b0;
    end else if (sleep_abort || (finish && !conv_done_irq_enable_ff)) begin
      sleep_off_ff <= 1'b1;
    end
  end

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_req) begin
          nxt_state = on_rc ? ST_RC_WAIT : ST_CONV;
        end
      end
      ST_RC_WAIT: begin
        if (go_cleared || sleep_abort) begin
          nxt_state = ST_RECOVER;
        end else if (wait_cnt_ff == `ADC_INSTR_CLKS - 3'h1) begin
          nxt_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (go_cleared || sleep_abort) begin
          nxt_state = ST_RECOVER;
        end else if (finish) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_RECOVER: begin
        if (half_tick && wait_cnt_ff == `ADC_RECOV_HALVES - 3'h1) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    // Disabling power cancels anything in flight
    if (!conv_enable_bit_ff) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Wait counter serves the instruction delay and the recovery delay
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt_ff <= 3'h0;
    end else if (nxt_state != state_ff) begin
      wait_cnt_ff <= 3'h0;
    end else if (state_ff == ST_RC_WAIT || (state_ff == ST_RECOVER && half_tick)) begin
      wait_cnt_ff <= wait_cnt_ff + 3'h1;
    end
  end

  // Successive approximation: one decision per bit period after setup
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt_ff <= 5'h00;
      bit_ix_ff   <= `ADC_MSB_INDEX;
      sar_ff      <= `ADC_SAR_SEED;
    end else if (state_ff != ST_CONV) begin
      half_cnt_ff <= 5'h00;
      bit_ix_ff   <= `ADC_MSB_INDEX;
      sar_ff      <= `ADC_SAR_SEED;
    end else if (half_tick) begin
      half_cnt_ff <= half_cnt_ff + 5'h01;
      if (half_cnt_ff > `ADC_SETUP_HALVES && !half_cnt_ff[0]) begin
        sar_ff <= decided;
        if (bit_ix_ff != 3'h0) begin
          sar_ff[bit_ix_ff - 3'h1] <= 1'b1;
          bit_ix_ff <= bit_ix_ff - 3'h1;
        end
      end
    end
  end

  // Result only moves on a full conversion, never on abort
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conv_result_ff <= `ADC_RESULT_RESET;
    end else if (finish) begin
      conv_result_ff <= decided;
    end
  end

  // ***************************************************************
  // Registered outputs
  // ***************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        `ADC_OFS_CTRL0:  rdata_ff <= {conv_clock_select_ff, channel_select_ff,
                                      state_ff == ST_CONV || state_ff == ST_RC_WAIT,
                                      1'b0, conv_enable_bit_ff};
        `ADC_OFS_CTRL1:  rdata_ff <= {5'h00, pin_config_select_ff};
        `ADC_OFS_RESULT: rdata_ff <= conv_result_ff;
        `ADC_OFS_IRQ:    rdata_ff <= {6'h00, conv_done_irq_enable_ff, conv_done_flag_ff};
        default:         rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // Timer clear follows every trigger; wake only for RC sleep completion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer1_clear_ff <= 1'b0;
      wake_ff         <= 1'b0;
    end else begin
      timer1_clear_ff <= special_trigger;
      wake_ff         <= finish && sleep_active && on_rc
                         && conv_done_irq_enable_ff;
    end
  end

  // Pin configuration, reference and analog front-end controls
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      analog_ff <= '0;
    end else begin
      analog_ff.powered     <= conv_enable_bit_ff && !sleep_off_ff;
      analog_ff.sample_hold <= conv_enable_bit_ff && !sleep_off_ff
                               && (state_ff == ST_IDLE || state_ff == ST_RC_WAIT);
      analog_ff.channel     <= channel_select_ff[1:0];
      analog_ff.ext_vref    <= pin_config_select_ff[0]
                               && pin_config_select_ff[2:1] != 2'h3;
      analog_ff.analog_mask <= (pin_config_select_ff[2:1] == 2'h3) ? 4'h0 :
                               {!pin_config_select_ff[0], !pin_config_select_ff[2], 2'h3};
      analog_ff.trial       <= sar_ff;
    end
  end

  assign rdata        = rdata_ff;
  assign timer1_clear = timer1_clear_ff;
  assign wake_request = wake_ff;
  assign analog       = analog_ff;

  // ***************************************************************
  // Checks
  // ***************************************************************
  abort_keeps_result_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_ff == ST_CONV && go_cleared && conv_enable_bit_ff
    |=> state_ff == ST_RECOVER && $stable(conv_result_ff))
    else $error("abort did not hold result");
  recover_exit_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_ff == ST_RECOVER && conv_enable_bit_ff && half_tick && wait_cnt_ff == 3'h3
    |=> state_ff == ST_IDLE ##1 analog.sample_hold || sleep_off_ff)
    else $error("recovery exit wrong");
  rc_start_delay_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_ff == ST_IDLE && start_req && on_rc && !sleep_active
    |=> (state_ff == ST_RC_WAIT)[*4] ##1 state_ff == ST_CONV || !conv_enable_bit_ff)
    else $error("rc start delay wrong");
  sleep_wake_a: assert property (@(posedge clock) disable iff (!rst_n)
    finish && sleep_active && on_rc && conv_done_irq_enable_ff
    |=> wake_request && conv_done_flag_ff)
    else $error("no wake on rc completion");
  sleep_power_a: assert property (@(posedge clock) disable iff (!rst_n)
    sleep_abort && conv_enable_bit_ff && !req.wr
    |=> conv_enable_bit_ff ##1 !analog.powered)
    else $error("sleep did not power down");
  trigger_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    special_trigger |=> timer1_clear)
    else $error("timer clear missing");
  done_flag_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    finish |=> conv_done_flag_ff && state_ff != ST_CONV && conv_result_ff == $past(decided))
    else $error("completion effects missing");
  disabled_go_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_ff == ST_IDLE && go_written && !conv_enable_bit_ff |=> state_ff == ST_IDLE)
    else $error("go accepted while disabled");
  reserved_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.addr == `ADC_OFS_CTRL1 |=> rdata[7:3] == 5'h00)
    else $error("reserved bits read nonzero");
  conv_length_a: assert property (@(posedge clock) disable iff (!rst_n)
    finish |-> half_cnt_ff == 5'h12 && bit_ix_ff == 3'h0)
    else $error("conversion length wrong");
endmodule : adc_conversion_control

// file: verification/analog_front_model.sv
`timescale 1ns/1ns
module analog_front_model
  import adc_pkg::*;
(
  // Clock
  input  wire logic        clock,
  // One input level byte per channel
  input  wire logic [31:0] levels,
  // Converter side
  input  wire analog_ctl_t analog,
  output logic             comp_in,
  output logic             rc_clk_in
);
  logic [7:0] held_ff = 8'h00;
  logic       junk_ff = 1'b0;

  // Free running RC oscillator, phase unrelated to the system clock
  initial rc_clk_in = 1'b0;
  always #97 rc_clk_in = ~rc_clk_in;

  // Holding capacitor follows the channel only while sampling
  always @(posedge clock) begin
    if (analog.sample_hold) held_ff <= levels[8*analog.channel +: 8];
    junk_ff <= ~junk_ff;
  end

  // Keep the trial bit if it does not exceed the held level; unpowered gives noise
  assign comp_in = analog.powered ? (analog.trial <= held_ff) : junk_ff;
endmodule : analog_front_model

// file: verification/adc_conversion_control_test.sv
`timescale 1ns/1ns
module adc_conversion_control_test
  import adc_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] half;
    logic [7:0] res;
  } row_t;
  logic        clock;
  logic        rst_n;
  reg_req_t    req;
  logic [7:0]  rdata;
  logic        sleep_active;
  logic        special_trigger;
  logic        timer1_clear;
  logic        wake_request;
  logic        rc_clk_in;
  logic        comp_in;
  analog_ctl_t analog;
  logic [7:0]  rd_val;
  int          error_cnt;
  int          n_checks;
  int          k;
  row_t        rows [8];

  adc_conversion_control #(.DIV_W(5)) i_dut (
    .clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata),
    .sleep_active(sleep_active), .special_trigger(special_trigger),
    .timer1_clear(timer1_clear), .wake_request(wake_request),
    .rc_clk_in(rc_clk_in), .comp_in(comp_in), .analog(analog));
  analog_front_model i_front (
    .clock(clock), .levels(32'hff00a55a), .analog(analog),
    .comp_in(comp_in), .rc_clk_in(rc_clk_in));

  // 100 MHz system clock
  always #5 clock = ~clock;

  // ***************************************************************
  // Bus tasks and checks
  // ***************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    // Data stand one cycle; taken mid-cycle so the caller resumes on an edge
    @(negedge clock);
    rd_val = rdata;
    @(posedge clock);
  endtask : rd
  // Polls go until it drops; bounded so a stuck converter is caught
  task automatic wait_idle();
    for (int i = 0; i < 300; i++) begin
      rd(8'h00);
      if (rd_val[2] === 1'b0) return;
    end
    error_cnt++;
    $display("ERROR %0t: conversion never finished", $time);
  endtask : wait_idle
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  // Watchdog, far beyond the expected few thousand cycles
  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    $display("ERROR %0t: watchdog expired", $time);
    give_verdict();
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    req = '0;
    sleep_active = 1'b0;
    special_trigger = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    // Control, half period in clocks (0 = RC), expected result
    rows = '{24'h01015a, 24'h0901a5, 24'h110100, 24'h1901ff,
             24'h4904a5, 24'h911000, 24'hc1005a, 24'h5904ff};
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    for (k = 0; k < 5; k++) begin
      rd(k[7:0]);
      chk(rd_val, 8'h00);
    end
    wr(8'h00, 8'hda);
    rd(8'h00);
    chk(rd_val, 8'hd8);
    wr(8'h01, 8'hff);
    rd(8'h01);
    chk(rd_val, 8'h07);
    wr(8'h00, 8'h04);
    rd(8'h00);
    chk(rd_val, 8'h00);
    for (k = 0; k < 8; k++) begin
      wr(8'h01, k[7:0]);
      repeat (2) @(posedge clock);
      chk({3'h0, analog.ext_vref, analog.analog_mask},
          {3'h0, k[0] & ~(k[2] & k[1]), ~k[0] & ~(k[2] & k[1]),
           k[2] ? {1'b0, ~k[1], ~k[1]} : 3'h7});
    end
    // Table of ordinary conversions over every clock code and channel
    for (k = 0; k < 8; k++) begin
      wr(8'h00, rows[k].ctrl);
      repeat (20) @(posedge clock);
      wr(8'h00, rows[k].ctrl | 8'h04);
      if (rows[k].half != 0) begin
        repeat (19 * rows[k].half - 4) @(posedge clock);
        rd(8'h00);
        chk(rd_val, rows[k].ctrl | 8'h04);
      end
      wait_idle();
      chk(rd_val, rows[k].ctrl);
      rd(8'h02);
      chk(rd_val, rows[k].res);
      rd(8'h03);
      chk(rd_val, 8'h01);
      wr(8'h03, 8'h00);
    end
    // Hardware start from the capture unit
    @(posedge clock);
    special_trigger <= 1'b1;
    @(posedge clock);
    special_trigger <= 1'b0;
    @(negedge clock);
    chk({7'h0, timer1_clear}, 8'h01);
    rd(8'h00);
    chk(rd_val, 8'h5d);
    wait_idle();
    wr(8'h03, 8'h00);
    // Abort mid-conversion, then recovery and automatic acquisition
    wr(8'h00, 8'h89);
    repeat (20) @(posedge clock);
    wr(8'h00, 8'h8d);
    repeat (40) @(posedge clock);
    wr(8'h00, 8'h89);
    repeat (20) @(posedge clock);
    chk({7'h0, analog.sample_hold}, 8'h00);
    repeat (60) @(posedge clock);
    chk({7'h0, analog.sample_hold}, 8'h01);
    rd(8'h02);
    chk(rd_val, 8'hff);
    rd(8'h03);
    chk(rd_val, 8'h00);
    // Sleep on a divided clock aborts the conversion
    wr(8'h00, 8'h8d);
    repeat (10) @(posedge clock);
    sleep_active <= 1'b1;
    repeat (4) @(posedge clock);
    chk({7'h0, analog.powered}, 8'h00);
    rd(8'h00);
    chk(rd_val, 8'h89);
    sleep_active <= 1'b0;
    repeat (80) @(posedge clock);
    // RC conversion in sleep with the interrupt enabled wakes the device
    wr(8'h03, 8'h02);
    wr(8'h00, 8'hc1);
    repeat (20) @(posedge clock);
    wr(8'h00, 8'hc5);
    sleep_active <= 1'b1;
    for (k = 0; k < 1000; k++) begin
      @(negedge clock);
      if (wake_request === 1'b1) break;
    end
    chk({7'h0, wake_request}, 8'h01);
    @(posedge clock);
    sleep_active <= 1'b0;
    wr(8'h03, 8'h00);
    // Same with the interrupt disabled: powered down, enable still set
    wr(8'h00, 8'hc5);
    sleep_active <= 1'b1;
    wait_idle();
    chk(rd_val, 8'hc1);
    chk({7'h0, analog.powered}, 8'h00);
    sleep_active <= 1'b0;
    wr(8'h00, 8'h00);
    repeat (2) @(posedge clock);
    chk({7'h0, analog.powered}, 8'h00);
    // Reset in mid-conversion
    wr(8'h00, 8'h81);
    wr(8'h00, 8'h85);
    repeat (10) @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    chk({7'h0, analog.powered}, 8'h00);
    rst_n <= 1'b1;
    // Result and done flag were non-zero before this reset
    for (k = 0; k < 4; k++) begin
      rd(k[7:0]);
      chk(rd_val, 8'h00);
    end
    give_verdict();
  end
endmodule : adc_conversion_control_test
